// ===== hw/spi_shift_core.sv
module spi_shift_core
  import spi_shift_core_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  input  wire logic        controller_out_pin_i,
  output logic             controller_out_pin_o,
  output logic             controller_out_pin_oe,
  input  wire logic        controller_in_pin_i,
  output logic             controller_in_pin_o,
  output logic             controller_in_pin_oe,
  input  wire logic        target_select_pin_i,
  output logic             target_select_pin_o,
  output logic             target_select_pin_oe
);
  import spi_shift_core_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [10:0]     ctrl;            // Control bits
  logic [5:0]      rate;            // [5:3] prescale_select, [2:0] rate_select
  logic [7:0]      tx_buf;          // Transmit buffer
  logic            tx_buffer_empty_flag;
  logic [7:0]      rx_buf;          // Receive buffer
  logic            rx_buffer_full_flag;
  logic            fault_flag;
  logic            fault_seen;      // Fault flag read while set
  logic [7:0]      shifter;         // Shift register
  logic            in_bit;          // Sampled input bit
  logic [3:0]      bit_cnt;         // Completed bits
  logic            half;            // 0: before sample edge, 1: before shift edge
  xfer_state_e     state;
  logic [2:0]      pre_cnt;         // Prescaler counter
  logic [7:0]      rate_cnt;        // Rate divider counter
  logic            sclk_int;        // Master clock before polarity
  logic            sel_out_n;       // Automatic select output
  logic [2:0]      sck_sync;        // Clock synchroniser
  logic [2:0]      ss_sync;         // Select synchroniser
  logic [2:0]      mo_sync;         // Controller-out input synchroniser
  logic [2:0]      mi_sync;         // Controller-in input synchroniser
  logic            sck_f;           // Filtered clock level
  logic            ss_f;            // Filtered select level
  logic            mo_f;
  logic            mi_f;
  logic            ap_valid;        // Registered bus address phase
  logic            ap_write;
  logic [7:0]      ap_addr;

  logic [10:0]     next_ctrl;
  logic [5:0]      next_rate;
  logic [7:0]      next_tx_buf;
  logic            next_tx_empty;
  logic [7:0]      next_rx_buf;
  logic            next_rx_full;
  logic            next_fault_flag;
  logic            next_fault_seen;
  logic [7:0]      next_shifter;
  logic            next_in_bit;
  logic [3:0]      next_bit_cnt;
  logic            next_half;
  xfer_state_e     next_state;
  logic [2:0]      next_pre_cnt;
  logic [7:0]      next_rate_cnt;
  logic            next_sclk_int;
  logic            next_sel_out_n;
  logic            next_sck_f;
  logic            next_ss_f;
  logic            next_mo_f;
  logic            next_mi_f;
  logic [31:0]     next_hrdata;

  // Decoded mode bits
  logic en, controller_mode_select, clock_phase_select, clock_polarity_select, lsbf, select_output_enable, fault_detect_enable, single_wire_select, bidir_output_enable;
  assign en      = ctrl[CTRL_ENABLE];
  assign controller_mode_select    = ctrl[CTRL_CONTROLLER];
  assign clock_phase_select    = ctrl[CTRL_PHASE];
  assign clock_polarity_select    = ctrl[CTRL_POLARITY];
  assign lsbf    = ctrl[CTRL_LSB_FIRST];
  assign select_output_enable    = ctrl[CTRL_SEL_OE];
  assign fault_detect_enable  = ctrl[CTRL_FAULT_EN];
  assign single_wire_select    = ctrl[CTRL_SINGLE_WIRE];
  assign bidir_output_enable = ctrl[CTRL_BIDIR_OE];

  // Bit leaving the shifter
  function automatic logic out_bit(input logic [7:0] s, input logic lsb);
    out_bit = lsb ? s[0] : s[7];
  endfunction

  // Shift in one bit on the far end
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic lsb,
                                          input logic b);
    shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_sync <= 3'h0;
      ss_sync  <= 3'h7;
      mo_sync  <= 3'h0;
      mi_sync  <= 3'h0;
      sck_f    <= 1'b0;
      ss_f     <= 1'b1;
      mo_f     <= 1'b0;
      mi_f     <= 1'b0;
    end else begin
      sck_sync <= {sck_sync[1:0], serial_clock_pin_i};
      ss_sync  <= {ss_sync[1:0], target_select_pin_i};
      mo_sync  <= {mo_sync[1:0], controller_out_pin_i};
      mi_sync  <= {mi_sync[1:0], controller_in_pin_i};
      sck_f    <= next_sck_f;
      ss_f     <= next_ss_f;
      mo_f     <= next_mo_f;
      mi_f     <= next_mi_f;
    end
  end

  // Filtered levels follow only when stages two and three agree
  always_comb begin
    next_sck_f = (sck_sync[1] == sck_sync[2]) ? sck_sync[2] : sck_f;
    next_ss_f  = (ss_sync[1] == ss_sync[2])   ? ss_sync[2]  : ss_f;
    next_mo_f  = (mo_sync[1] == mo_sync[2])   ? mo_sync[2]  : mo_f;
    next_mi_f  = (mi_sync[1] == mi_sync[2])   ? mi_sync[2]  : mi_f;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master bit-rate generator: one-cycle tick per half serial clock
  logic       tick;
  logic [7:0] rate_top;    // Half-period count minus one in prescaled units
  assign rate_top = 8'((9'h002 << rate[2:0]) >> 1) - 8'h01;
  assign tick = (pre_cnt == rate[5:3]) && (rate_cnt == rate_top);

  always_comb begin
    next_pre_cnt  = pre_cnt;
    next_rate_cnt = rate_cnt;
    if (state == ST_IDLE || !controller_mode_select) begin
      next_pre_cnt  = 3'h0;
      next_rate_cnt = 8'h00;
    end else if (pre_cnt == rate[5:3]) begin
      next_pre_cnt  = 3'h0;
      next_rate_cnt = tick ? 8'h00 : rate_cnt + 8'h01;
    end else begin
      next_pre_cnt  = pre_cnt + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave clock edge detection on the filtered level
  logic sck_edge, ss_active, mode_fault_in;
  assign sck_edge      = next_sck_f != sck_f;
  assign ss_active     = !ss_f;
  assign mode_fault_in = controller_mode_select && fault_detect_enable && !select_output_enable && !ss_f;

  // Serial event: sample edge when half==0, shift edge when half==1
  logic ev;
  assign ev = controller_mode_select ? (tick && state != ST_IDLE) : (sck_edge && ss_active);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic bus_take, rd_status, wr_data;
  assign bus_take  = hsel && hready && htrans[1];
  assign rd_status = bus_take && !hwrite && haddr[7:0] == STATUS_OFFSET;
  assign wr_data   = ap_valid && ap_write && ap_addr == DATA_OFFSET;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine and registers
  always_comb begin
    next_ctrl       = ctrl;
    next_rate       = rate;
    next_tx_buf     = tx_buf;
    next_tx_empty   = tx_buffer_empty_flag;
    next_rx_buf     = rx_buf;
    next_rx_full    = rx_buffer_full_flag;
    next_fault_flag = fault_flag;
    next_fault_seen = fault_seen;
    next_shifter    = shifter;
    next_in_bit     = in_bit;
    next_bit_cnt    = bit_cnt;
    next_half       = half;
    next_state      = state;
    next_sclk_int   = sclk_int;
    next_sel_out_n  = sel_out_n;
    next_hrdata     = 32'h0;
    // Register reads
    if (bus_take && !hwrite) begin
      case (haddr[7:0])
        CTRL_OFFSET:   next_hrdata = {21'h0, ctrl};
        RATE_OFFSET:   next_hrdata = {26'h0, rate};
        STATUS_OFFSET: next_hrdata = {24'h0, rx_buffer_full_flag, 1'b0,
                                      tx_buffer_empty_flag, fault_flag, 4'h0};
        DATA_OFFSET:   next_hrdata = {24'h0, rx_buf};
        default:       next_hrdata = 32'h0;
      endcase
      if (haddr[7:0] == DATA_OFFSET) begin
        next_rx_full = 1'b0;
      end
    end
    if (rd_status && fault_flag) begin
      next_fault_seen = 1'b1;
    end
    // Register writes in data phase
    if (ap_valid && ap_write) begin
      case (ap_addr)
        CTRL_OFFSET: begin
          next_ctrl = hwdata[10:0];
          if (fault_seen) begin
            next_fault_flag = 1'b0;
            next_fault_seen = 1'b0;
          end
        end
        RATE_OFFSET: next_rate = hwdata[5:0];
        DATA_OFFSET: begin
          next_tx_buf   = hwdata[7:0];
          next_tx_empty = 1'b0;
        end
        default: ;
      endcase
    end
    // Transfer sequencing
    case (state)
      ST_IDLE: begin
        next_sclk_int  = 1'b0;
        next_sel_out_n = 1'b1;
        next_bit_cnt   = 4'h0;
        next_half      = 1'b0;
        if (controller_mode_select && !tx_buffer_empty_flag) begin
          next_shifter   = tx_buf;
          next_tx_empty  = !wr_data;
          next_sel_out_n = 1'b0;
          next_state     = clock_phase_select ? ST_LEAD : ST_SHIFT;
        end else if (!controller_mode_select && ss_active) begin
          if (!tx_buffer_empty_flag) begin
            next_shifter  = tx_buf;
            next_tx_empty = !wr_data;
          end
          next_state = clock_phase_select ? ST_LEAD : ST_SHIFT;
        end
      end
      ST_LEAD: begin
        // Phase one: first edge only shifts the first bit out
        if (ev) begin
          next_sclk_int = 1'b1;
          next_state    = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (ev && !half) begin
          next_in_bit   = controller_mode_select ? (single_wire_select ? mo_f : mi_f)
                               : (single_wire_select ? mi_f : mo_f);
          next_sclk_int = !sclk_int;
          next_half     = 1'b1;
        end else if (ev && half) begin
          next_shifter  = shift_in(shifter, lsbf, in_bit);
          next_bit_cnt  = bit_cnt + 4'h1;
          next_half     = 1'b0;
          next_sclk_int = !sclk_int;
          if (bit_cnt + 4'h1 == FRAME_BITS) begin
            if (!rx_buffer_full_flag) begin
              next_rx_buf  = shift_in(shifter, lsbf, in_bit);
              next_rx_full = 1'b1;
            end
            next_sclk_int = 1'b0;
            next_bit_cnt  = 4'h0;
            if (clock_phase_select) begin
              next_sel_out_n = 1'b1;
            end
            // A byte written in this very cycle stays queued for the next frame
            if (controller_mode_select && !tx_buffer_empty_flag && clock_phase_select) begin
              next_shifter  = tx_buf;
              next_tx_empty = !wr_data;
              next_sel_out_n = 1'b0;
              next_state    = ST_LEAD;
            end else begin
              next_state = clock_phase_select ? ST_IDLE : ST_TAIL;
            end
          end
        end
      end
      ST_TAIL: begin
        // Phase zero: select held half a clock past the last edge
        if (controller_mode_select ? ev : !ss_active) begin
          next_sel_out_n = 1'b1;
          next_state     = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Slave deselected mid-frame abandons the frame
    if (!controller_mode_select && !ss_active && state != ST_IDLE) begin
      next_state = ST_IDLE;
    end
    // Mode fault reaction
    if (en && mode_fault_in) begin
      next_fault_flag              = 1'b1;
      next_ctrl[CTRL_CONTROLLER]   = 1'b0;
      next_state                   = ST_IDLE;
    end
    // Disabled module: transfer engine and buffer flags back to rest
    if (!en) begin
      next_state    = ST_IDLE;
      next_rx_full  = 1'b0;
      next_sclk_int = 1'b0;
      next_sel_out_n = 1'b1;
      next_bit_cnt  = 4'h0;
      next_half     = 1'b0;
      if (!(ap_valid && ap_write && ap_addr == DATA_OFFSET)) begin
        next_tx_empty = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl                 <= CTRL_RESET;
      rate                 <= RATE_RESET;
      tx_buf               <= 8'h00;
      tx_buffer_empty_flag <= 1'b1;
      rx_buf               <= 8'h00;
      rx_buffer_full_flag  <= 1'b0;
      fault_flag           <= 1'b0;
      fault_seen           <= 1'b0;
      shifter              <= 8'h00;
      in_bit               <= 1'b0;
      bit_cnt              <= 4'h0;
      half                 <= 1'b0;
      state                <= ST_IDLE;
      pre_cnt              <= 3'h0;
      rate_cnt             <= 8'h00;
      sclk_int             <= 1'b0;
      sel_out_n            <= 1'b1;
      hrdata               <= 32'h0;
      ap_valid             <= 1'b0;
      ap_write             <= 1'b0;
      ap_addr              <= 8'h00;
    end else begin
      ctrl                 <= next_ctrl;
      rate                 <= next_rate;
      tx_buf               <= next_tx_buf;
      tx_buffer_empty_flag <= next_tx_empty;
      rx_buf               <= next_rx_buf;
      rx_buffer_full_flag  <= next_rx_full;
      fault_flag           <= next_fault_flag;
      fault_seen           <= next_fault_seen;
      shifter              <= next_shifter;
      in_bit               <= next_in_bit;
      bit_cnt              <= next_bit_cnt;
      half                 <= next_half;
      state                <= next_state;
      pre_cnt              <= next_pre_cnt;
      rate_cnt             <= next_rate_cnt;
      sclk_int             <= next_sclk_int;
      sel_out_n            <= next_sel_out_n;
      hrdata               <= next_hrdata;
      ap_valid             <= bus_take;
      ap_write             <= hwrite;
      ap_addr              <= haddr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexing, registered so every output comes from a flip-flop
  logic next_sck_o, next_sck_oe, next_mo_o, next_mo_oe, next_mi_o, next_mi_oe;
  logic next_ss_o, next_ss_oe, dbit;
  always_comb begin
    dbit        = out_bit(next_shifter, lsbf);
    next_sck_o  = next_sclk_int ^ clock_polarity_select;
    next_sck_oe = en && controller_mode_select && !mode_fault_in;
    next_mo_o   = dbit;
    next_mi_o   = dbit;
    next_mo_oe  = en && controller_mode_select && !mode_fault_in && (!single_wire_select || bidir_output_enable);
    next_mi_oe  = en && !controller_mode_select && !single_wire_select && ss_active;
    if (single_wire_select && !controller_mode_select) begin
      next_mi_oe = en && bidir_output_enable;
    end
    next_ss_o   = next_sel_out_n;
    next_ss_oe  = en && controller_mode_select && fault_detect_enable && select_output_enable;
    if (!en) begin
      next_sck_oe = 1'b0;
      next_mo_oe  = 1'b0;
      next_mi_oe  = 1'b0;
      next_ss_oe  = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_clock_pin_o    <= 1'b0;
      serial_clock_pin_oe   <= 1'b0;
      controller_out_pin_o  <= 1'b0;
      controller_out_pin_oe <= 1'b0;
      controller_in_pin_o   <= 1'b0;
      controller_in_pin_oe  <= 1'b0;
      target_select_pin_o   <= 1'b1;
      target_select_pin_oe  <= 1'b0;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
    end else begin
      serial_clock_pin_o    <= next_sck_o;
      serial_clock_pin_oe   <= next_sck_oe;
      controller_out_pin_o  <= next_mo_o;
      controller_out_pin_oe <= next_mo_oe;
      controller_in_pin_o   <= next_mi_o;
      controller_in_pin_oe  <= next_mi_oe;
      target_select_pin_o   <= next_ss_o;
      target_select_pin_oe  <= next_ss_oe;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_disabled_released;
    @(posedge hclk) disable iff (!hresetn)
      !en |=> !serial_clock_pin_oe && !controller_out_pin_oe && !target_select_pin_oe
              && !controller_in_pin_oe;
  endproperty
  a_disabled_released: assert property (p_disabled_released)
    else $error("pins driven while disabled");

  property p_disable_flags;
    @(posedge hclk) disable iff (!hresetn)
      !en && !wr_data |=> tx_buffer_empty_flag && !rx_buffer_full_flag;
  endproperty
  a_disable_flags: assert property (p_disable_flags)
    else $error("disable did not reset flags");

  property p_fault;
    @(posedge hclk) disable iff (!hresetn)
      en && mode_fault_in |=> fault_flag && !controller_mode_select ##1 !serial_clock_pin_oe;
  endproperty
  a_fault: assert property (p_fault)
    else $error("mode fault not handled");

  property p_start;
    @(posedge hclk) disable iff (!hresetn)
      en && state == ST_IDLE && controller_mode_select && !tx_buffer_empty_flag && !mode_fault_in && !wr_data
      |=> state != ST_IDLE && tx_buffer_empty_flag;
  endproperty
  a_start: assert property (p_start)
    else $error("transfer did not start");

  property p_overrun;
    @(posedge hclk) disable iff (!hresetn)
      rx_buffer_full_flag && !(bus_take && !hwrite) |=> $stable(rx_buf);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("full receiver overwritten");

  property p_slave_clock_in;
    @(posedge hclk) disable iff (!hresetn)
      !controller_mode_select |=> !serial_clock_pin_oe;
  endproperty
  a_slave_clock_in: assert property (p_slave_clock_in)
    else $error("slave drives clock");

  property p_polarity;
    @(posedge hclk) disable iff (!hresetn)
      en && controller_mode_select && state == ST_IDLE && $stable(ctrl) |=> serial_clock_pin_o == $past(clock_polarity_select);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("idle clock level wrong");

  property p_sel_out;
    @(posedge hclk) disable iff (!hresetn)
      en && controller_mode_select && fault_detect_enable && select_output_enable |=> target_select_pin_oe;
  endproperty
  a_sel_out: assert property (p_sel_out)
    else $error("select output not driven");

  property p_bitcnt;
    @(posedge hclk) disable iff (!hresetn)
      bit_cnt < FRAME_BITS;
  endproperty
  a_bitcnt: assert property (p_bitcnt)
    else $error("bit count past frame");

  c_master_xfer: cover property (@(posedge hclk) disable iff (!hresetn)
    controller_mode_select && state == ST_TAIL ##1 state == ST_IDLE);
  c_rx_full: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(rx_buffer_full_flag));
  c_fault: cover property (@(posedge hclk) disable iff (!hresetn) $rose(fault_flag));

endmodule // spi_shift_core

// ===== hw/spi_shift_core_pkg.sv
package spi_shift_core_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;  // Control bits
  localparam logic [7:0] RATE_OFFSET   = 8'h04;  // Prescale and rate select
  localparam logic [7:0] STATUS_OFFSET = 8'h08;  // Flags
  localparam logic [7:0] DATA_OFFSET   = 8'h0c;  // Serial data

  // Control field positions
  localparam int CTRL_LSB_FIRST   = 0;
  localparam int CTRL_SEL_OE      = 1;
  localparam int CTRL_PHASE       = 2;
  localparam int CTRL_POLARITY    = 3;
  localparam int CTRL_CONTROLLER  = 4;
  localparam int CTRL_ENABLE      = 6;
  localparam int CTRL_BIDIR_OE    = 8;
  localparam int CTRL_SINGLE_WIRE = 9;
  localparam int CTRL_FAULT_EN    = 10;

  // Status field positions
  localparam int STAT_FAULT    = 4;
  localparam int STAT_TX_EMPTY = 5;
  localparam int STAT_RX_FULL  = 7;

  // Values after reset
  localparam logic [10:0] CTRL_RESET = 11'h004;
  localparam logic [5:0]  RATE_RESET = 6'h00;

  // Bits per frame
  localparam logic [3:0] FRAME_BITS = 4'h8;

  // Transfer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TAIL  = 2'b11
  } xfer_state_e;

endpackage

// ===== test/serial_target_model.sv
// Far-side slave: clock idles low, drives on rising edge, samples on falling
module serial_target_model (
  input  wire logic       sck,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output logic [7:0]      bits
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;  // Shift register, also the received byte
  assign rx_byte = sh;
  initial begin
    miso = 1'b0;
    sh   = 8'h00;
    bits = 8'h00;
  end
  // Load only when newly selected
  always @(negedge sel_n) sh = tx_byte;
  always @(posedge sck) if (!sel_n) miso = sh[7];
  always @(negedge sck) if (!sel_n) begin
    sh   = {sh[6:0], mosi};
    bits = bits + 8'h01;
  end
  // Released line shows the inverse of its last level
  always @(posedge sel_n) miso = ~miso;
endmodule // serial_target_model

// ===== test/test_spi_shift_core.sv
module test_spi_shift_core;
  timeunit 1ns;
  timeprecision 1ns;
  import spi_shift_core_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, miso;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sck_o, sck_oe, co_o, co_oe, ci_o, ci_oe, ss_o, ss_oe;
  logic [7:0] p_tx, p_rx, p_bits, b, sr;
  logic sck_in, mosi_in, ss_in;  // Far master levels when the core is a slave
  int fails, cmp_count;
  // Wire levels from the core's enables, else the far side's drive
  wire logic sck_w  = sck_oe ? sck_o : sck_in;
  wire logic ss_w   = ss_oe ? ss_o : ss_in;
  wire logic mosi_w = co_oe ? co_o : mosi_in;
  wire logic miso_w = ci_oe ? ci_o : miso;
  spi_shift_core i_spi_shift_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
    .controller_out_pin_i(mosi_w), .controller_out_pin_o(co_o),
    .controller_out_pin_oe(co_oe), .controller_in_pin_i(miso_w),
    .controller_in_pin_o(ci_o), .controller_in_pin_oe(ci_oe), .target_select_pin_i(ss_w),
    .target_select_pin_o(ss_o), .target_select_pin_oe(ss_oe));
  serial_target_model i_serial_target_model (.sck(sck_w), .sel_n(ss_w), .mosi(mosi_w),
    .tx_byte(p_tx), .miso(miso), .rx_byte(p_rx), .bits(p_bits));
  ////////////////////////////////////////////////////////////////////////////
  task test_done;
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Edges until ready is sampled high, bounded
  task step;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      fails++;
      test_done;
    end
  endtask
  // One single-word transfer; read data lands in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    step;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    step;
    rd = hrdata;
  endtask
  task rx_wait;
    int n;
    n = 0;
    do begin
      bus(1'b0, STATUS_OFFSET, 32'h0);
      n++;
    end while (rd[STAT_RX_FULL] !== 1'b1 && n < 200);
    if (rd[STAT_RX_FULL] !== 1'b1) begin
      fails++;
      test_done;
    end
  endtask
  // Far master, phase zero, clock idle low, msb first; select high between frames
  task sxfer(input logic [7:0] t, output logic [7:0] r);
    ss_in <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= t[i];
      repeat (10) @(posedge hclk);
      r[i] = miso_w;
      sck_in <= 1'b1;
      repeat (10) @(posedge hclk);
      sck_in <= 1'b0;
    end
    repeat (10) @(posedge hclk);
    ss_in <= 1'b1;
    repeat (10) @(posedge hclk);
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    test_done;
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; p_tx = 8'h31; fails = 0; cmp_count = 0;
    sck_in = 1'b0;
    mosi_in = 1'b0;
    ss_in = 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, CTRL_OFFSET, 32'h0); chk("ctrl", {21'h0, CTRL_RESET}, rd);
    bus(1'b0, STATUS_OFFSET, 32'h0); chk("status", 32'h20, rd);
    bus(1'b0, 8'h10, 32'h0); chk("unmapped", 32'h0, rd);
    chk("pins oe", 32'h0, {28'h0, sck_oe, co_oe, ci_oe, ss_oe});
    chk("hresp", 32'h0, {31'h0, hresp});
    // Half period of eight bus cycles leaves room for the input synchroniser
    bus(1'b1, RATE_OFFSET, 32'h0a);
    bus(1'b0, RATE_OFFSET, 32'h0); chk("rate", 32'h0a, rd);
    // Master, phase one, auto select; both bit orders
    for (int l = 0; l < 2; l++) begin
      bus(1'b1, CTRL_OFFSET, 32'h456 | 32'(l));
      bus(1'b0, STATUS_OFFSET, 32'h0);
      chk("clock idle", 32'h2, {30'h0, sck_oe, sck_o});
      bus(1'b1, DATA_OFFSET, 32'h12);
      rx_wait;
      bus(1'b0, DATA_OFFSET, 32'h0);
      chk("rx", (l == 1) ? 32'h8c : 32'h31, rd);
      chk("far rx", (l == 1) ? 32'h48 : 32'h12, {24'h0, p_rx});
    end
    // Back to back with no read between: second received byte dropped silently
    b = p_bits;
    bus(1'b1, DATA_OFFSET, 32'h55);
    bus(1'b1, DATA_OFFSET, 32'h66);
    for (int n = 0; n < 800 && !(p_bits == b + 8'd16 && ss_w === 1'b1); n++) @(posedge hclk);
    if (!(p_bits == b + 8'd16 && ss_w === 1'b1)) begin
      fails++;
      test_done;
    end
    bus(1'b0, STATUS_OFFSET, 32'h0); chk("full", 32'ha0, rd);
    chk("far rx2", 32'h66, {24'h0, p_rx});
    bus(1'b0, DATA_OFFSET, 32'h0); chk("kept", 32'h8c, rd);
    bus(1'b0, STATUS_OFFSET, 32'h0); chk("no overrun", 32'h20, rd);
    // Slave, phase zero: far master swaps one byte each way
    bus(1'b1, CTRL_OFFSET, 32'h040);
    bus(1'b1, DATA_OFFSET, 32'ha5);
    sxfer(8'h3c, sr);
    chk("slave out", 32'ha5, {24'h0, sr});
    bus(1'b0, STATUS_OFFSET, 32'h0); chk("slave status", 32'ha0, rd);
    bus(1'b0, DATA_OFFSET, 32'h0); chk("slave rx", 32'h3c, rd);
    // Master with fault input: another master pulls the select low
    ss_in <= 1'b0;
    bus(1'b1, CTRL_OFFSET, 32'h450);
    repeat (8) @(posedge hclk);
    bus(1'b0, STATUS_OFFSET, 32'h0); chk("fault", 32'h30, rd);
    bus(1'b0, CTRL_OFFSET, 32'h0); chk("fault mode", 32'h440, rd);
    chk("fault oe", 32'h0, {30'h0, sck_oe, co_oe});
    ss_in <= 1'b1;
    bus(1'b1, CTRL_OFFSET, 32'h004);
    bus(1'b0, STATUS_OFFSET, 32'h0); chk("off status", 32'h20, rd);
    chk("off oe", 32'h0, {28'h0, sck_oe, co_oe, ci_oe, ss_oe});
    test_done;
  end
endmodule // test_spi_shift_core
